/* File: logic/exec_pkg.sv */
// Summary of operation
// - Carry branches go to pc+k+1 on carry set or clear; one cycle untaken, two taken.
// - Signed branches test negative xor overflow; greater-equal on 0, less-than on 1.
// - Half-carry and T-flag branches follow their flag and leave flags alone.
// - Overflow branches follow the overflow flag; one cycle untaken, two taken.
// - Interrupt-state branches follow the global interrupt enable flag, no flag effects.
// - I/O bit set and clear force one bit, take two cycles, no flags change.
// - Rotates pass carry in and the outgoing bit to carry; update Z C N V.
// - Arithmetic right shift keeps bit 7 and updates Z C N V in one cycle.
// - Bit store copies a register bit to T; bit load copies T back.
// - Each status flag can be set or cleared alone by index.
// - Bit operations reach only I/O addresses 0x00 to 0x1f.
// - I/O bit set and clear write the whole byte back: w1c bits as zero, the addressed bit forced.
// - Some status flags clear when software writes one to them.
// - I/O transfers use 0x00 to 0x3f; data space adds 0x20.
// - Extended I/O 0x60 to 0xff is reached only by data-space access.
package exec_pkg;
    typedef enum logic [4:0] {
        op_nop, op_branch_clear, op_branch_set, op_branch_greater_equal,
        op_branch_less_than, op_logical_left_shift, op_logical_right_shift,
        op_rotate_left_carry, op_rotate_right_carry, op_arith_right_shift,
        op_swap, op_flag_set_indexed, op_flag_clear_indexed, op_bit_to_tflag,
        op_tflag_to_bit, op_io_bit_set, op_io_bit_clear, op_io_in, op_io_out,
        op_data_load, op_data_store
    } op_type;

    // Status flag bit positions
    localparam logic [2:0] flag_c = 3'h0;
    localparam logic [2:0] flag_z = 3'h1;
    localparam logic [2:0] flag_n = 3'h2;
    localparam logic [2:0] flag_v = 3'h3;
    localparam logic [2:0] flag_s = 3'h4;
    localparam logic [2:0] flag_h = 3'h5;
    localparam logic [2:0] flag_t = 3'h6;
    localparam logic [2:0] flag_i = 3'h7;
    localparam logic [7:0] flags_reset = 8'h00;

    localparam logic [7:0] io_bit_last = 8'h1f;
    localparam logic [7:0] io_last = 8'h3f;
    localparam logic [7:0] io_data_offset = 8'h20;
    localparam logic [7:0] ext_io_first = 8'h60;
    localparam logic [7:0] ext_io_last = 8'hff;
    localparam logic [7:0] data_io_last = 8'h5f;
    localparam logic [7:0] pc_one = 8'h01;
endpackage

/* File: logic/shift_unit.sv */
`timescale 1ns/1ps
module shift_unit (
    // Operation
    input wire exec_pkg::op_type op,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    // Result
    output logic [7:0] result,
    output logic carry_out,
    output logic writes_flags
);
    always_comb begin
        result = operand;
        carry_out = carry_in;
        writes_flags = 1'b1;
        case (op)
            exec_pkg::op_logical_left_shift: begin
                result = {operand[6:0], 1'b0};
                carry_out = operand[7];
            end
            exec_pkg::op_logical_right_shift: begin
                result = {1'b0, operand[7:1]};
                carry_out = operand[0];
            end
            exec_pkg::op_rotate_left_carry: begin
                result = {operand[6:0], carry_in};
                carry_out = operand[7];
            end
            exec_pkg::op_rotate_right_carry: begin
                result = {carry_in, operand[7:1]};
                carry_out = operand[0];
            end
            exec_pkg::op_arith_right_shift: begin
                result = {operand[7], operand[7:1]};
                carry_out = operand[0];
            end
            exec_pkg::op_swap: begin
                result = {operand[3:0], operand[7:4]};
                writes_flags = 1'b0;
            end
            default: begin
                writes_flags = 1'b0;
            end
        endcase
    end
endmodule

/* File: logic/branch_bit_shift_exec.sv */
`timescale 1ns/1ps
module branch_bit_shift_exec (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Instruction
    input wire logic issue,
    input wire exec_pkg::op_type op,
    input wire logic [7:0] operand,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] addr,
    input wire logic [7:0] offset_k,
    input wire logic [7:0] store_data,
    // I/O space
    input wire logic [7:0] io_read_data,
    input wire logic [7:0] io_w1c_mask,
    // Results
    output logic [7:0] pc,
    output logic [7:0] status_flags,
    output logic [7:0] result_data,
    output logic result_valid,
    output logic busy,
    output logic io_write,
    output logic [7:0] io_addr,
    output logic [7:0] io_write_data,
    output logic addr_error
);
    logic [7:0] pc_reg, pc_next;
    logic [7:0] flags_reg, flags_next;
    logic [7:0] result_reg;
    logic valid_reg;
    logic busy_reg;
    logic io_write_reg;
    logic [7:0] io_addr_reg, io_data_reg;
    logic err_reg;
    logic [7:0] shift_result;
    logic shift_carry, shift_flags;
    logic taken;
    logic [7:0] hold_addr;
    logic [2:0] hold_bit;
    logic hold_set;
    // Marks the write-back cycle of an I/O bit op; a taken branch is busy as well
    logic rmw_reg;
    logic [7:0] keep_bits;

    shift_unit shifter (
        .op(op),
        .operand(operand),
        .carry_in(flags_reg[exec_pkg::flag_c]),
        .result(shift_result),
        .carry_out(shift_carry),
        .writes_flags(shift_flags)
    );

    function automatic logic io_bit_ok(input logic [7:0] a);
        io_bit_ok = (a <= exec_pkg::io_bit_last);
    endfunction

    // Both I/O bit ops share the range check and the write-back path
    function automatic logic is_io_bit_op(input exec_pkg::op_type o);
        is_io_bit_op = (o == exec_pkg::op_io_bit_set) || (o == exec_pkg::op_io_bit_clear);
    endfunction

    // W1c bits go back as zero so a bit op clears no pending flag except the one a bit set addresses
    assign keep_bits = io_read_data & ~io_w1c_mask;

    // Branch condition; the flag is chosen by bit_sel for set/clear forms
    always_comb begin
        taken = 1'b0;
        case (op)
            exec_pkg::op_branch_set: taken = flags_reg[bit_sel];
            exec_pkg::op_branch_clear: taken = ~flags_reg[bit_sel];
            exec_pkg::op_branch_greater_equal: begin
                taken = ~(flags_reg[exec_pkg::flag_n] ^ flags_reg[exec_pkg::flag_v]);
            end
            exec_pkg::op_branch_less_than: begin
                taken = flags_reg[exec_pkg::flag_n] ^ flags_reg[exec_pkg::flag_v];
            end
            default: taken = 1'b0;
        endcase
    end

    // Offset wraps inside the 8-bit pc; a longer reach needs a wider pc
    always_comb begin
        pc_next = pc_reg + exec_pkg::pc_one;
        if (taken) begin
            pc_next = pc_reg + offset_k + exec_pkg::pc_one;
        end
    end

    // Flag updates; branches never touch flags
    // V after a shift is N xor C of the shifted result
    always_comb begin
        logic [7:0] r;
        r = shift_result;
        flags_next = flags_reg;
        if (issue && !busy_reg) begin
            if (shift_flags) begin
                flags_next[exec_pkg::flag_c] = shift_carry;
                flags_next[exec_pkg::flag_z] = (r == 8'h00);
                flags_next[exec_pkg::flag_n] = r[7];
                flags_next[exec_pkg::flag_v] = r[7] ^ shift_carry;
            end else if (op == exec_pkg::op_flag_set_indexed) begin
                flags_next[bit_sel] = 1'b1;
            end else if (op == exec_pkg::op_flag_clear_indexed) begin
                flags_next[bit_sel] = 1'b0;
            end else if (op == exec_pkg::op_bit_to_tflag) begin
                flags_next[exec_pkg::flag_t] = operand[bit_sel];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= exec_pkg::flags_reset;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Taken branch and I/O bit ops occupy a second cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= 8'h00;
            busy_reg <= 1'b0;
            hold_addr <= 8'h00;
            hold_bit <= 3'h0;
            hold_set <= 1'b0;
            rmw_reg <= 1'b0;
        end else if (busy_reg) begin
            // An issue during the second cycle is dropped; the caller must wait it out
            busy_reg <= 1'b0;
            rmw_reg <= 1'b0;
        end else if (issue) begin
            pc_reg <= pc_next;
            busy_reg <= taken;
            if (is_io_bit_op(op) && io_bit_ok(addr)) begin
                busy_reg <= 1'b1;
                rmw_reg <= 1'b1;
                hold_addr <= addr;
                hold_bit <= bit_sel;
                hold_set <= (op == exec_pkg::op_io_bit_set);
            end
        end
    end

    // Read-modify-write in second cycle; w1c bits written zero so they stay intact
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            io_write_reg <= 1'b0;
            io_addr_reg <= 8'h00;
            io_data_reg <= 8'h00;
            err_reg <= 1'b0;
        end else begin
            io_write_reg <= 1'b0;
            err_reg <= 1'b0;
            if (rmw_reg) begin
                // The I/O side must still present hold_addr's content in this cycle
                io_write_reg <= 1'b1;
                io_addr_reg <= hold_addr;
                io_data_reg <= keep_bits | (8'h01 << hold_bit);
                if (!hold_set) begin
                    io_data_reg <= keep_bits & ~(8'h01 << hold_bit);
                end
            end else if (issue && !busy_reg) begin
                case (op)
                    exec_pkg::op_io_bit_set, exec_pkg::op_io_bit_clear: begin
                        err_reg <= !io_bit_ok(addr);
                    end
                    exec_pkg::op_io_out: begin
                        io_write_reg <= (addr <= exec_pkg::io_last);
                        io_addr_reg <= addr;
                        io_data_reg <= store_data;
                        err_reg <= (addr > exec_pkg::io_last);
                    end
                    exec_pkg::op_data_store: begin
                        if (addr >= exec_pkg::io_data_offset && addr <= exec_pkg::data_io_last) begin
                            io_write_reg <= 1'b1;
                            io_addr_reg <= addr - exec_pkg::io_data_offset;
                            io_data_reg <= store_data;
                        end else if (addr >= exec_pkg::ext_io_first) begin
                            io_write_reg <= 1'b1;
                            io_addr_reg <= addr;
                            io_data_reg <= store_data;
                        end else begin
                            err_reg <= 1'b1;
                        end
                    end
                    default: err_reg <= 1'b0;
                endcase
            end
        end
    end

    // Register results
    // result_valid pulses for every accepted instruction, branches included
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= 8'h00;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= 1'b0;
            if (issue && !busy_reg) begin
                valid_reg <= 1'b1;
                case (op)
                    exec_pkg::op_tflag_to_bit: begin
                        result_reg <= operand;
                        result_reg[bit_sel] <= flags_reg[exec_pkg::flag_t];
                    end
                    exec_pkg::op_io_in, exec_pkg::op_data_load: result_reg <= io_read_data;
                    default: result_reg <= shift_result;
                endcase
            end
        end
    end

    assign pc = pc_reg;
    assign status_flags = flags_reg;
    assign result_data = result_reg;
    assign result_valid = valid_reg;
    assign busy = busy_reg;
    assign io_write = io_write_reg;
    assign io_addr = io_addr_reg;
    assign io_write_data = io_data_reg;
    assign addr_error = err_reg;
endmodule

/* File: tb/exec_checker.sv */
`timescale 1ns/1ps
module exec_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Instruction
    input wire logic issue,
    input wire exec_pkg::op_type op,
    input wire logic [7:0] operand,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] addr,
    input wire logic [7:0] offset_k,
    // I/O and results
    input wire logic [7:0] io_read_data,
    input wire logic [7:0] io_w1c_mask,
    input wire logic [7:0] pc,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] result_data,
    input wire logic busy,
    input wire logic io_write,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_write_data
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic go;
    logic flag_set_indexed;
    logic bit_op;
    assign go = issue && !busy;
    assign flag_set_indexed = go && op == exec_pkg::op_branch_set;
    assign bit_op = go && op inside {exec_pkg::op_io_bit_set, exec_pkg::op_io_bit_clear};
    a_taken_jump: assert property (flag_set_indexed && status_flags[bit_sel] |=> busy
        && pc == $past(pc) + $past(offset_k) + 8'h01)
        else $error("bad taken branch");
    a_untaken_short: assert property (flag_set_indexed && !status_flags[bit_sel] |=> !busy)
        else $error("slow untaken branch");
    a_branch_flags: assert property (go && op == exec_pkg::op_branch_clear
        |=> $stable(status_flags))
        else $error("branch changed flags");
    a_signed_less: assert property (go && op == exec_pkg::op_branch_less_than
        |=> busy == $past(status_flags[2] ^ status_flags[3]))
        else $error("bad signed branch");
    a_bit_range: assert property (bit_op && addr > 8'h1f |=> !io_write [*2])
        else $error("bit op wrote high address");
    a_io_bit_set: assert property (go && op == exec_pkg::op_io_bit_set && addr <= 8'h1f
        |=> busy ##1 io_write && io_addr == $past(addr, 2)
        && io_write_data == (($past(io_read_data) & ~$past(io_w1c_mask))
        | (8'h01 << $past(bit_sel, 2))))
        else $error("bad bit set write");
    a_swap_keep: assert property (go && op == exec_pkg::op_swap
        |=> $stable(status_flags) && result_data == {$past(operand[3:0]), $past(operand[7:4])})
        else $error("bad swap");
    a_tflag_copy: assert property (go && op == exec_pkg::op_bit_to_tflag
        |=> status_flags[6] == $past(operand[bit_sel]))
        else $error("bad bit store");
endmodule

/* File: tb/io_space.sv */
`timescale 1ns/1ps
module io_space (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Access
    input wire logic [7:0] addr,
    input wire logic io_write,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_write_data,
    output logic [7:0] io_read_data,
    output logic [7:0] io_w1c_mask
);
    // Low nibble of this register holds flags that clear on a written one
    localparam logic [7:0] w1c_addr = 8'h16;
    logic [7:0] mem [0:255];
    assign io_read_data = mem[addr];
    assign io_w1c_mask = (addr == w1c_addr) ? 8'h0f : 8'h00;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= 8'(i) ^ 8'h5a;
            end
        end else if (io_write && io_addr == w1c_addr) begin
            mem[io_addr] <= (io_write_data & 8'hf0)
                | (mem[io_addr] & ~io_write_data & 8'h0f);
        end else if (io_write) begin
            mem[io_addr] <= io_write_data;
        end
    end
endmodule

/* File: tb/tb_branch_bit_shift_exec.sv */
`timescale 1ns/1ps
module tb_branch_bit_shift_exec;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic issue = 1'b0;
    exec_pkg::op_type op = exec_pkg::op_nop;
    logic [7:0] operand = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] offset_k = 8'h05;
    logic [7:0] store_data = 8'h3c;
    logic [7:0] io_read_data, io_w1c_mask, pc, status_flags, result_data, io_addr, io_write_data;
    logic result_valid, busy, io_write, addr_error, w, er;
    logic [7:0] p, f, e, wa, wd;
    int fail_count = 0;
    int num_checks = 0;
    initial begin
        forever #25 clock = ~clock;
    end
    branch_bit_shift_exec u_dut (.clock(clock), .rst_n(rst_n), .issue(issue), .op(op),
        .operand(operand), .bit_sel(bit_sel), .addr(addr), .offset_k(offset_k),
        .store_data(store_data), .io_read_data(io_read_data), .io_w1c_mask(io_w1c_mask),
        .pc(pc), .status_flags(status_flags), .result_data(result_data),
        .result_valid(result_valid), .busy(busy), .io_write(io_write), .io_addr(io_addr),
        .io_write_data(io_write_data), .addr_error(addr_error));
    io_space u_io (.clock(clock), .rst_n(rst_n), .addr(addr), .io_write(io_write),
        .io_addr(io_addr), .io_write_data(io_write_data), .io_read_data(io_read_data),
        .io_w1c_mask(io_w1c_mask));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input exec_pkg::op_type o, input logic [7:0] d, input logic [2:0] b,
        input logic [7:0] a);
        @(posedge clock);
        op <= o;
        operand <= d;
        bit_sel <= b;
        addr <= a;
        issue <= 1'b1;
        @(posedge clock);
        issue <= 1'b0;
        #1;
    endtask
    // Watches three cycles so a write one edge late is still caught
    task automatic obs();
        w = 1'b0;
        er = 1'b0;
        repeat (3) begin
            if (io_write) begin
                w = 1'b1;
                wa = io_addr;
                wd = io_write_data;
            end
            if (addr_error) begin
                er = 1'b1;
            end
            @(posedge clock);
            #1;
        end
    endtask
    task automatic t_branch();
        for (int i = 0; i < 8; i++) begin
            run(exec_pkg::op_flag_set_indexed, 8'h00, 3'(i), 8'h00);
            chk(status_flags[i], 1'b1);
            p = pc;
            f = status_flags;
            run(exec_pkg::op_branch_set, 8'h00, 3'(i), 8'h00);
            chk(pc, p + offset_k + 8'h01);
            chk(status_flags, f);
            run(exec_pkg::op_flag_clear_indexed, 8'h00, 3'(i), 8'h00);
            chk(status_flags[i], 1'b0);
            run(exec_pkg::op_branch_set, 8'h00, 3'(i), 8'h00);
            chk(busy, 1'b0);
            run(exec_pkg::op_branch_clear, 8'h00, 3'(i), 8'h00);
            chk(busy, 1'b1);
        end
        run(exec_pkg::op_flag_set_indexed, 8'h00, exec_pkg::flag_n, 8'h00);
        for (int j = 0; j < 2; j++) begin
            run(j ? exec_pkg::op_flag_set_indexed : exec_pkg::op_flag_clear_indexed, 8'h00,
                exec_pkg::flag_v, 8'h00);
            run(exec_pkg::op_branch_less_than, 8'h00, 3'h0, 8'h00);
            chk(busy, j == 0);
            run(exec_pkg::op_branch_greater_equal, 8'h00, 3'h0, 8'h00);
            chk(busy, j == 1);
        end
        $display("branch test done");
    endtask
    task automatic t_shift();
        exec_pkg::op_type ops [6] = '{exec_pkg::op_logical_left_shift,
            exec_pkg::op_logical_right_shift,
            exec_pkg::op_rotate_left_carry, exec_pkg::op_rotate_right_carry,
            exec_pkg::op_arith_right_shift, exec_pkg::op_logical_right_shift};
        logic [7:0] din [6] = '{8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h01};
        logic [7:0] res [6] = '{8'h02, 8'h40, 8'h03, 8'hc0, 8'hc0, 8'h00};
        run(exec_pkg::op_flag_set_indexed, 8'h00, exec_pkg::flag_c, 8'h00);
        for (int i = 0; i < 6; i++) begin
            run(ops[i], din[i], 3'h0, 8'h00);
            chk(result_data, res[i]);
            f = {4'h0, ~res[i][7], res[i][7], res[i] == 8'h00, 1'b1};
            chk(status_flags & 8'h0f, f);
        end
        run(exec_pkg::op_swap, 8'h81, 3'h0, 8'h00);
        chk(result_data, 8'h18);
        chk(result_valid, 1'b1);
        run(exec_pkg::op_bit_to_tflag, 8'h10, 3'h3, 8'h00);
        chk(status_flags[6], 1'b0);
        run(exec_pkg::op_bit_to_tflag, 8'h10, 3'h4, 8'h00);
        chk(status_flags[6], 1'b1);
        f = status_flags;
        run(exec_pkg::op_tflag_to_bit, 8'h00, 3'h2, 8'h00);
        chk(result_data, 8'h04);
        chk(status_flags, f);
        $display("shift test done");
    endtask
    task automatic t_io();
        run(exec_pkg::op_io_bit_set, 8'h00, 3'h7, 8'h16);
        p = io_read_data;
        e = (io_read_data & ~io_w1c_mask) | 8'h80;
        obs();
        chk(wd, e);
        chk(wa, 8'h16);
        chk(io_read_data, p | 8'h80);
        run(exec_pkg::op_io_bit_clear, 8'h00, 3'h0, 8'h05);
        e = io_read_data & 8'hfe;
        obs();
        chk(wd, e);
        run(exec_pkg::op_io_bit_set, 8'h00, 3'h0, 8'h20);
        obs();
        chk({er, w}, 8'h02);
        run(exec_pkg::op_io_out, 8'h00, 3'h0, 8'h40);
        obs();
        chk({er, w}, 8'h02);
        run(exec_pkg::op_data_store, 8'h00, 3'h0, 8'h25);
        obs();
        chk(wa, 8'h05);
        chk(wd, store_data);
        run(exec_pkg::op_io_out, 8'h00, 3'h0, 8'h10);
        obs();
        chk({er, w}, 8'h01);
        chk(wa, 8'h10);
        run(exec_pkg::op_io_in, 8'h00, 3'h0, 8'h10);
        chk(result_data, 8'h3c);
        run(exec_pkg::op_data_store, 8'h00, 3'h0, 8'h10);
        obs();
        chk({er, w}, 8'h02);
        run(exec_pkg::op_data_store, 8'h00, 3'h0, 8'h60);
        obs();
        chk(wa, 8'h60);
        $display("io test done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_branch();
        t_shift();
        t_io();
        final_report();
    end
    // 67 instructions of at most five cycles each fit well inside this
    initial begin
        repeat (4000) @(posedge clock);
        fail_count++;
        final_report();
    end
endmodule
bind branch_bit_shift_exec exec_checker u_chk (.clock(clock), .rst_n(rst_n), .issue(issue),
    .op(op), .operand(operand), .bit_sel(bit_sel), .addr(addr), .offset_k(offset_k),
    .io_read_data(io_read_data), .io_w1c_mask(io_w1c_mask), .pc(pc),
    .status_flags(status_flags), .result_data(result_data), .busy(busy),
    .io_write(io_write), .io_addr(io_addr), .io_write_data(io_write_data));
